/* fsp_pkg.sv */
// package: constants and types for the flash status poller
//------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------
// Notes on behaviour
// - on timing-limit high, controller writes the reset command only if two further reads still toggle.
// - polling interrupted by other work restarts from the first step.
// - confirm acceptance by toggling, sample erase-timeout before and after adds.
// - erase-timeout high after an add: that add may be lost.
// - buffer-abort flag high: controller writes the buffer-abort reset sequence.
// - never read the program-suspended sector; other sectors give data.
// - write-buffer polling uses the last loaded buffer address.
package fsp_pkg;
  localparam int ADDR_W = 25;
  localparam int DATA_W = 16;
  // flash status bit positions
  localparam int BIT_ABORT = 1;
  localparam int BIT_SEC_TOG = 2;
  localparam int BIT_ERASE_TO = 3;
  localparam int BIT_TLIMIT = 5;
  localparam int BIT_PRI_TOG = 6;
  localparam int BIT_POLL = 7;
  // flash command words
  localparam logic [15:0] CMD_RESET = 16'h00F0;
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_ABORT_RST = 16'h00F0;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 25'h000_0555;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 25'h000_02AA;
  // flash bus cycle timing
  localparam int T_CYCLE_NS = 70;
  localparam int CLK_NS = 25;
  localparam int CYC_BUS = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  // controller register map (word index == byte offset / 4)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_ERSTAT = 4'h4;
  // ctrl bits
  localparam int CTRL_POLL = 0;
  localparam int CTRL_ADD = 1;
  localparam int CTRL_WBUF = 2;
  localparam int CTRL_WRITE = 3;
  localparam int CTRL_READ = 4;
  // status codes
  localparam logic [2:0] RES_NONE = 3'h0;
  localparam logic [2:0] RES_OK = 3'h1;
  localparam logic [2:0] RES_TLIMIT = 3'h2;
  localparam logic [2:0] RES_ABORT = 3'h3;
  localparam logic [2:0] RES_ADD_LOST = 3'h4;
  localparam logic [2:0] RES_ADD_OK = 3'h5;
  typedef enum logic [3:0] {
    FSP_IDLE, FSP_CYC, FSP_RD1, FSP_RD2, FSP_CHK, FSP_RD3, FSP_RD4, FSP_FIN,
    FSP_RST, FSP_AB1, FSP_AB2, FSP_AB3, FSP_PRE, FSP_ADD, FSP_POST
  } fsp_state_t;
endpackage

/* fsp_bus_if.sv */
// interface: single flash bus cycle request and result
`timescale 1ns/1ps
interface fsp_bus_if;
  logic start;
  logic wr;
  logic [fsp_pkg::ADDR_W-1:0] addr;
  logic [fsp_pkg::DATA_W-1:0] wdata;
  logic done;
  logic [fsp_pkg::DATA_W-1:0] rdata;
  modport master (output start, output wr, output addr, output wdata, input done, input rdata);
  modport slave (input start, input wr, input addr, input wdata, output done, output rdata);
endinterface

/* fsp_cycle.sv */
// module: runs one asynchronous flash read or write cycle on the pins
`timescale 1ns/1ps
module fsp_cycle (
  input wire logic core_clk,
  input wire logic reset,
  fsp_bus_if.slave bus,
  output logic [fsp_pkg::ADDR_W-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [fsp_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [fsp_pkg::DATA_W-1:0] flash_dq_in
);
  logic [fsp_pkg::DATA_W-1:0] dq_s1;
  logic [fsp_pkg::DATA_W-1:0] dq_s2;
  logic [3:0] cnt;
  logic busy;
  logic done;
  logic [fsp_pkg::DATA_W-1:0] rdata;
  wire last = busy && cnt == 4'(fsp_pkg::CYC_BUS);
  assign bus.done = done;
  assign bus.rdata = rdata;
  // two-stage sampling of the data pins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
    end else begin
      dq_s1 <= flash_dq_in;
      dq_s2 <= dq_s1;
    end
  end
  // each cycle deasserts chip enable so toggle bits advance
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      done <= 1'b0;
      rdata <= 16'h0000;
      flash_addr <= 25'h000_0000;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
    end else begin
      done <= last;
      if (bus.start && !busy) begin
        busy <= 1'b1;
        cnt <= 4'h0;
        flash_addr <= bus.addr;
        flash_dq_out <= bus.wdata;
        flash_dq_oe <= bus.wr;
        flash_ce_n <= 1'b0;
        flash_oe_n <= bus.wr;
        flash_we_n <= !bus.wr;
      end else if (last) begin
        busy <= 1'b0;
        rdata <= dq_s2;
        flash_ce_n <= 1'b1;
        flash_oe_n <= 1'b1;
        flash_we_n <= 1'b1;
        flash_dq_oe <= 1'b0;
      end else if (busy) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

/* fsp_top.sv */
// module: host-side status poller for a parallel flash
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
module fsp_top (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [fsp_pkg::ADDR_W-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [fsp_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [fsp_pkg::DATA_W-1:0] flash_dq_in
);
  fsp_bus_if bus ();
  fsp_pkg::fsp_state_t state;
  fsp_pkg::fsp_state_t ret_state;
  logic [fsp_pkg::ADDR_W-1:0] op_addr;
  logic [fsp_pkg::DATA_W-1:0] op_data;
  logic [fsp_pkg::DATA_W-1:0] first_rd;
  logic [fsp_pkg::DATA_W-1:0] last_rd;
  logic [fsp_pkg::DATA_W-1:0] pre_rd;
  logic [2:0] result;
  logic busy;
  logic wbuf;
  logic start;
  logic wr;
  logic [fsp_pkg::ADDR_W-1:0] cyc_addr;
  logic [fsp_pkg::DATA_W-1:0] cyc_wdata;
  logic [fsp_pkg::DATA_W-1:0] rd_data_reg;
  logic [31:0] rdata;

  fsp_cycle u_cycle (
    .core_clk(core_clk),
    .reset(reset),
    .bus(bus),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in)
  );
  assign bus.start = start;
  assign bus.wr = wr;
  assign bus.addr = cyc_addr;
  assign bus.wdata = cyc_wdata;

  //------------------------------------------------------------
  // status decode
  //------------------------------------------------------------
  function automatic logic toggled(input logic [15:0] a, input logic [15:0] b);
    toggled = a[fsp_pkg::BIT_PRI_TOG] != b[fsp_pkg::BIT_PRI_TOG];
  endfunction
  wire cmd_go = reg_wr && reg_addr == fsp_pkg::REG_CTRL && !busy;
  wire toggling = toggled(first_rd, bus.rdata);
  wire tlimit_hi = first_rd[fsp_pkg::BIT_TLIMIT] || bus.rdata[fsp_pkg::BIT_TLIMIT];
  wire abort_hi = wbuf && bus.rdata[fsp_pkg::BIT_ABORT];
  wire etimeout_hi = bus.rdata[fsp_pkg::BIT_ERASE_TO];
  // secondary toggle compared across the reads around an add
  wire sec_tog = pre_rd[fsp_pkg::BIT_SEC_TOG] != last_rd[fsp_pkg::BIT_SEC_TOG];

  //------------------------------------------------------------
  // register read
  //------------------------------------------------------------
  // read decode, unmapped reads return zero
  always_comb begin
    case (reg_addr)
      fsp_pkg::REG_CTRL: rdata = {31'h0000_0000, busy};
      fsp_pkg::REG_ADDR: rdata = {7'h00, op_addr};
      fsp_pkg::REG_DATA: rdata = {16'h0000, rd_data_reg};
      fsp_pkg::REG_STAT: rdata = {29'h0000_0000, result};
      fsp_pkg::REG_ERSTAT: rdata = {30'h0000_0000, sec_tog, pre_rd[fsp_pkg::BIT_ERASE_TO]};
      default: rdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rdata : 32'h0000_0000;
    end
  end

  //------------------------------------------------------------
  // sequencer
  //------------------------------------------------------------
  // one flash cycle at a time; cycles follow back to back
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= fsp_pkg::FSP_IDLE;
      ret_state <= fsp_pkg::FSP_IDLE;
      op_addr <= 25'h000_0000;
      op_data <= 16'h0000;
      first_rd <= 16'h0000;
      last_rd <= 16'h0000;
      pre_rd <= 16'h0000;
      result <= fsp_pkg::RES_NONE;
      busy <= 1'b0;
      wbuf <= 1'b0;
      start <= 1'b0;
      wr <= 1'b0;
      cyc_addr <= 25'h000_0000;
      cyc_wdata <= 16'h0000;
      rd_data_reg <= 16'h0000;
    end else begin
      start <= 1'b0;
      if (reg_wr && !busy && reg_addr == fsp_pkg::REG_ADDR) begin
        op_addr <= reg_wdata[fsp_pkg::ADDR_W-1:0];
      end
      if (reg_wr && !busy && reg_addr == fsp_pkg::REG_DATA) begin
        op_data <= reg_wdata[fsp_pkg::DATA_W-1:0];
      end
      case (state)
        fsp_pkg::FSP_IDLE: begin
          if (cmd_go) begin
            busy <= 1'b1;
            result <= fsp_pkg::RES_NONE;
            wbuf <= reg_wdata[fsp_pkg::CTRL_WBUF];
            start <= 1'b1;
            cyc_addr <= op_addr;
            cyc_wdata <= op_data;
            wr <= reg_wdata[fsp_pkg::CTRL_WRITE];
            if (reg_wdata[fsp_pkg::CTRL_ADD]) begin
              wr <= 1'b0;
              state <= fsp_pkg::FSP_PRE;
            end else if (reg_wdata[fsp_pkg::CTRL_POLL]) begin
              wr <= 1'b0;
              state <= fsp_pkg::FSP_RD1;
            end else begin
              ret_state <= fsp_pkg::FSP_FIN;
              state <= fsp_pkg::FSP_CYC;
            end
          end
        end
        fsp_pkg::FSP_CYC: if (bus.done) begin
          rd_data_reg <= bus.rdata;
          state <= ret_state;
        end
        fsp_pkg::FSP_RD1: if (bus.done) begin
          first_rd <= bus.rdata;
          start <= 1'b1;
          state <= fsp_pkg::FSP_RD2;
        end
        fsp_pkg::FSP_RD2: if (bus.done) begin
          last_rd <= bus.rdata;
          if (!toggling) begin
            result <= fsp_pkg::RES_OK;
            state <= fsp_pkg::FSP_FIN;
          end else if (abort_hi) begin
            result <= fsp_pkg::RES_ABORT;
            state <= fsp_pkg::FSP_AB1;
            wr <= 1'b1;
            cyc_addr <= fsp_pkg::ADDR_UNLOCK1;
            cyc_wdata <= fsp_pkg::CMD_UNLOCK1;
            start <= 1'b1;
          end else if (tlimit_hi) begin
            state <= fsp_pkg::FSP_RD3;
            start <= 1'b1;
          end else begin
            start <= 1'b1;
            state <= fsp_pkg::FSP_RD1;
          end
        end
        fsp_pkg::FSP_RD3: if (bus.done) begin
          first_rd <= bus.rdata;
          start <= 1'b1;
          state <= fsp_pkg::FSP_RD4;
        end
        fsp_pkg::FSP_RD4: if (bus.done) begin
          if (!toggling) begin
            result <= fsp_pkg::RES_OK;
            state <= fsp_pkg::FSP_FIN;
          end else begin
            result <= fsp_pkg::RES_TLIMIT;
            wr <= 1'b1;
            cyc_addr <= op_addr;
            cyc_wdata <= fsp_pkg::CMD_RESET;
            start <= 1'b1;
            ret_state <= fsp_pkg::FSP_FIN;
            state <= fsp_pkg::FSP_CYC;
          end
        end
        fsp_pkg::FSP_AB1: if (bus.done) begin
          cyc_addr <= fsp_pkg::ADDR_UNLOCK2;
          cyc_wdata <= fsp_pkg::CMD_UNLOCK2;
          start <= 1'b1;
          state <= fsp_pkg::FSP_AB2;
        end
        fsp_pkg::FSP_AB2: if (bus.done) begin
          cyc_addr <= fsp_pkg::ADDR_UNLOCK1;
          cyc_wdata <= fsp_pkg::CMD_ABORT_RST;
          start <= 1'b1;
          ret_state <= fsp_pkg::FSP_FIN;
          state <= fsp_pkg::FSP_CYC;
        end
        fsp_pkg::FSP_PRE: if (bus.done) begin
          pre_rd <= bus.rdata;
          if (etimeout_hi) begin
            result <= fsp_pkg::RES_ADD_LOST;
            state <= fsp_pkg::FSP_FIN;
          end else begin
            wr <= 1'b1;
            cyc_wdata <= op_data;
            start <= 1'b1;
            state <= fsp_pkg::FSP_ADD;
          end
        end
        fsp_pkg::FSP_ADD: if (bus.done) begin
          wr <= 1'b0;
          start <= 1'b1;
          state <= fsp_pkg::FSP_POST;
        end
        fsp_pkg::FSP_POST: if (bus.done) begin
          last_rd <= bus.rdata;
          // a risen flag means the window closed around the add
          result <= etimeout_hi ? fsp_pkg::RES_ADD_LOST : fsp_pkg::RES_ADD_OK;
          state <= fsp_pkg::FSP_FIN;
        end
        fsp_pkg::FSP_FIN: begin
          busy <= 1'b0;
          wr <= 1'b0;
          state <= fsp_pkg::FSP_IDLE;
        end
        default: state <= fsp_pkg::FSP_IDLE;
      endcase
    end
  end
  // secondary toggle reported for software sector decode
endmodule

/* fsp_props.sv */
// checker: pin and register port timing of the flash status poller
`timescale 1ns/1ps
module fsp_props (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [fsp_pkg::ADDR_W-1:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [fsp_pkg::DATA_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe
);
  logic [3:0] idle_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  //------------------------------------------------------------
  // helper: clocks since chip enable was last low
  //------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) idle_cnt <= 4'h0;
    else if (!flash_ce_n) idle_cnt <= 4'h0;
    else if (idle_cnt != 4'hF) idle_cnt <= idle_cnt + 4'h1;
  end
  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its slot");
  cycle_frame_a: assert property ($fell(flash_ce_n) |-> !flash_ce_n [*4] ##1 flash_ce_n)
    else $error("flash cycle length wrong");
  oe_we_excl_a: assert property (!(!flash_oe_n && !flash_we_n))
    else $error("output and write enable both low");
  idle_pins_a: assert property (flash_ce_n |-> flash_oe_n && flash_we_n)
    else $error("strobe low without chip enable");
  addr_hold_a: assert property (!flash_ce_n && !$fell(flash_ce_n) |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved in a cycle");
  write_drive_a: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("write without driving data");
  read_float_a: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("bus driven during read");
  ctrl_start_a: assert property (reg_wr && reg_addr == fsp_pkg::REG_CTRL && idle_cnt > 4'h4 |=> flash_ce_n ##1 !flash_ce_n)
    else $error("operation did not start");
endmodule
bind fsp_top fsp_props fsp_props_inst (.core_clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
  .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_out, .flash_dq_oe);

/* fsp_flash_model.sv */
// model: flash device status behaviour as seen on its pins
`timescale 1ns/1ps
module fsp_flash_model (
  input wire logic [fsp_pkg::ADDR_W-1:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [fsp_pkg::DATA_W-1:0] flash_dq_out,
  output logic [fsp_pkg::DATA_W-1:0] flash_dq_in
);
  logic busy = 1'b0;
  logic [1:0] bank = 2'h0;
  int cnt = 0;
  int fault = 0; // 1 timing limit, 2 buffer abort
  logic erasing = 1'b0;
  logic eto = 1'b0;
  logic close_add = 1'b0;
  int n_add = 0;
  logic tog = 1'b0;
  logic rd_seen = 1'b0;
  logic wr_seen = 1'b0;
  logic [24:0] wa, ra;
  logic [15:0] wd;
  logic [15:0] last = 16'h0000;
  logic [40:0] h0, h1, h2;
  wire [15:0] arr = flash_addr[15:0] ^ 16'h5A5A; // array content
  wire stat = busy && flash_addr[24:23] == bank;
  // secondary toggle follows the read toggle only while erasing
  wire sec = erasing & tog;
  wire [15:0] sw = {8'h00, ~arr[7], tog, fault == 1, 1'b0, eto, sec, fault == 2, 1'b0};
  // released bus shows the inverse of the last word
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? (stat ? sw : arr) : ~last;
  // latch what a cycle carries while it is active
  always @* begin
    if (!flash_ce_n && !flash_oe_n) begin
      last = stat ? sw : arr;
      ra = flash_addr;
      rd_seen = 1'b1;
    end
    if (!flash_ce_n && !flash_we_n) begin
      wa = flash_addr;
      wd = flash_dq_out;
      wr_seen = 1'b1;
    end
  end
  // end of cycle: advance busy state, act on writes
  always @(posedge flash_ce_n) begin
    if (rd_seen && busy && ra[24:23] == bank) begin
      tog = ~tog;
      if (cnt > 0) cnt = cnt - 1;
      if (cnt == 0 && fault == 0 && !erasing) busy = 1'b0;
    end
    if (wr_seen) begin
      h2 = h1;
      h1 = h0;
      h0 = {wa, wd};
      if (fault == 1 && wd == fsp_pkg::CMD_RESET) begin
        busy = 1'b0;
        fault = 0;
      end
      if (fault == 2 && wd == fsp_pkg::CMD_ABORT_RST && h1[15:0] == fsp_pkg::CMD_UNLOCK2
          && h2[15:0] == fsp_pkg::CMD_UNLOCK1) begin
        busy = 1'b0;
        fault = 0;
      end
      if (erasing && close_add) eto = 1'b1;
      else if (erasing && !eto) n_add = n_add + 1;
    end
    rd_seen = 1'b0;
    wr_seen = 1'b0;
  end
endmodule

/* fsp_top_tb.sv */
// testbench: drives the status poller against the flash model
`timescale 1ns/1ps
module fsp_top_tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rv;
  logic [24:0] flash_addr;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
  logic [15:0] flash_dq_out, flash_dq_in;
  int n_fail = 0;
  int tests_run = 0;
  always #12.5 core_clk = ~core_clk;
  fsp_top fsp_top_inst (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_out, .flash_dq_oe, .flash_dq_in);
  fsp_flash_model fsp_flash_model_inst (.flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .flash_dq_out, .flash_dq_in);
  //------------------------------------------------------------
  // shared tasks
  //------------------------------------------------------------
  task automatic chk(input string name, input logic [40:0] seen, input logic [40:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic arm(input logic b, input int c, input int f, input logic e, input logic cl);
    fsp_flash_model_inst.busy = b;
    fsp_flash_model_inst.cnt = c;
    fsp_flash_model_inst.fault = f;
    fsp_flash_model_inst.erasing = e;
    fsp_flash_model_inst.eto = 1'b0;
    fsp_flash_model_inst.close_add = cl;
  endtask
  // start one operation, wait for idle, leave the result code in rv
  task automatic op(input logic [31:0] ctrl, input logic [24:0] a, input logic [15:0] d);
    wr(fsp_pkg::REG_ADDR, {7'h00, a});
    wr(fsp_pkg::REG_DATA, {16'h0000, d});
    wr(fsp_pkg::REG_CTRL, ctrl);
    rv = 32'h0000_0001;
    for (int i = 0; i < 400 && rv[0] !== 1'b0; i++) rd(fsp_pkg::REG_CTRL, rv);
    chk("idle", rv[0], 1'b0);
    rd(fsp_pkg::REG_STAT, rv);
  endtask
  //------------------------------------------------------------
  // scenarios
  //------------------------------------------------------------
  task automatic t_reset;
    rd(fsp_pkg::REG_STAT, rv);
    chk("stat_rst", rv, fsp_pkg::RES_NONE);
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF, rv);
    chk("unmapped", rv, 0);
  endtask
  task automatic t_poll;
    arm(1'b1, 3, 0, 1'b0, 1'b0);
    op(32'h0000_0001, 25'h000_0100, 16'h0000);
    chk("poll_ok", rv, fsp_pkg::RES_OK);
    chk("poll_addr", fsp_flash_model_inst.ra, 25'h000_0100);
    arm(1'b1, 0, 1, 1'b0, 1'b0);
    op(32'h0000_0001, 25'h000_0100, 16'h0000);
    chk("tlimit", rv, fsp_pkg::RES_TLIMIT);
    chk("reset_cmd", fsp_flash_model_inst.h0[15:0], fsp_pkg::CMD_RESET);
  endtask
  task automatic t_abort;
    arm(1'b1, 0, 2, 1'b0, 1'b0);
    op(32'h0000_0005, 25'h000_0200, 16'h1234);
    chk("abort", rv, fsp_pkg::RES_ABORT);
    chk("last_addr", fsp_flash_model_inst.ra, 25'h000_0200);
    chk("ab1", fsp_flash_model_inst.h2, {fsp_pkg::ADDR_UNLOCK1, fsp_pkg::CMD_UNLOCK1});
    chk("ab2", fsp_flash_model_inst.h1, {fsp_pkg::ADDR_UNLOCK2, fsp_pkg::CMD_UNLOCK2});
    chk("ab3", fsp_flash_model_inst.h0, {fsp_pkg::ADDR_UNLOCK1, fsp_pkg::CMD_ABORT_RST});
  endtask
  task automatic t_add;
    arm(1'b1, 0, 0, 1'b1, 1'b0);
    op(32'h0000_0002, 25'h001_0000, 16'h0030);
    chk("add_ok", rv, fsp_pkg::RES_ADD_OK);
    chk("add_wr", fsp_flash_model_inst.h0, {25'h001_0000, 16'h0030});
    chk("add_cnt", fsp_flash_model_inst.n_add, 1);
    arm(1'b1, 0, 0, 1'b1, 1'b1);
    op(32'h0000_0002, 25'h002_0000, 16'h0030);
    chk("add_lost", rv, fsp_pkg::RES_ADD_LOST);
    rd(fsp_pkg::REG_ERSTAT, rv);
    chk("pre_eto", rv[0], 1'b0);
    chk("sec_tog", rv[1], 1'b1);
  endtask
  task automatic t_rw;
    arm(1'b1, 1000, 0, 1'b0, 1'b0);
    op(32'h0000_0000, 25'h180_0044, 16'h0000);
    rd(fsp_pkg::REG_DATA, rv);
    chk("other_bank", rv[15:0], 16'h5A1E);
    op(32'h0000_0008, 25'h100_0008, 16'hBEEF);
    chk("write", fsp_flash_model_inst.h0, {25'h100_0008, 16'hBEEF});
    arm(1'b0, 0, 0, 1'b0, 1'b0);
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_reset;
    t_poll;
    t_abort;
    t_add;
    t_rw;
    wrap_up;
  end
  // watchdog against a hung handshake
  initial begin
    #(25 * 20000);
    n_fail++;
    wrap_up;
  end
endmodule
